// File: rtl/blfg_pkg.sv
// Shared constants and types for the backlight fade and pin port block.
package blfg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] WHITE_LED_CONTROL_OFF = 8'h03;
  localparam logic [7:0] PRIMARY_CURRENT_CODE_OFF = 8'h04;
  localparam logic [7:0] SECONDARY_CURRENT_CODE_OFF = 8'h05;
  localparam logic [7:0] PIN_DIRECTION_CONTROL_OFF = 8'h06;
  localparam logic [7:0] PIN_LEVEL_DATA_OFF = 8'h07;
  localparam logic [7:0] EXT_DIM_CONTROL_OFF = 8'h2B;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_W = 6;
  localparam int PWM_SEL_BIT = 4;
  localparam int PIN_CNT = 3;
  localparam int DIM_W = 2;
  localparam int CODE_W = 8;
  localparam int STEP_CNT_W = 16;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [2:0] PIN_BITS_RST = 3'h0;
  localparam logic [15:0] STEP_CNT_RST = 16'h0000;

  // ----------------------------------------------------------------------
  // Timing: full-scale fade times and the per-step interval they imply
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int FADE_SLOW_MS = 1300;
  localparam int FADE_FAST_MS = 650;
  localparam int FULL_SCALE_STEPS = 255;
  // Rounded down so a full ramp never overruns the programmed time.
  localparam int FADE_SLOW_STEP_CYC =
    FADE_SLOW_MS * (CLK_HZ / 1000) / FULL_SCALE_STEPS;
  localparam int FADE_FAST_STEP_CYC =
    FADE_FAST_MS * (CLK_HZ / 1000) / FULL_SCALE_STEPS;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Bit order matches the control register, bit 5 down to bit 0.
  typedef struct packed {
    logic fade_rate_select;
    logic fade_target_select;
    logic fade_enable;
    logic shared_dac_mode;
    logic primary_string_enable;
    logic secondary_string_enable;
  } blfg_white_led_ctrl_s;

  // Bit 1 primary, bit 0 secondary.
  typedef struct packed {
    logic primary_ext_dim_enable;
    logic secondary_ext_dim_enable;
  } blfg_ext_dim_s;

  // One register access from the serial slave engine.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } blfg_reg_req_s;

endpackage

// File: rtl/blfg_fade_ramp.sv
// Single-string fade ramp that walks the applied current code to a target.
`timescale 1ns/1ps

module blfg_fade_ramp #(
  parameter int unsigned P_SLOW_STEP_CYC = blfg_pkg::FADE_SLOW_STEP_CYC,
  parameter int unsigned P_FAST_STEP_CYC = blfg_pkg::FADE_FAST_STEP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_target,
  input wire logic i_fade_active,
  input wire logic i_fade_fast,
  output logic [7:0] o_code
);

  // ----------------------------------------------------------------------
  // Step timing
  // ----------------------------------------------------------------------
  logic [7:0] code_reg;
  logic [7:0] code_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  wire [15:0] step_last = i_fade_fast ? 16'(P_FAST_STEP_CYC - 1)
                                      : 16'(P_SLOW_STEP_CYC - 1);
  wire at_target = (code_reg == i_target);
  // A rate change mid-ramp may leave the count past the new limit.
  wire step_due = (cnt_reg >= step_last);

  // One step per interval, so a partial change takes a share of the time.
  always_comb begin
    code_next = code_reg;
    cnt_next = cnt_reg + 16'h0001;
    if (!i_fade_active) begin
      code_next = i_target;
      cnt_next = blfg_pkg::STEP_CNT_RST;
    end else if (at_target) begin
      cnt_next = blfg_pkg::STEP_CNT_RST;
    end else if (step_due) begin
      cnt_next = blfg_pkg::STEP_CNT_RST;
      code_next = (code_reg < i_target) ? code_reg + 8'h01
                                        : code_reg - 8'h01;
    end
  end

  // Applied code and interval counter.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      code_reg <= blfg_pkg::CODE_RST;
      cnt_reg <= blfg_pkg::STEP_CNT_RST;
    end else begin
      code_reg <= code_next;
      cnt_reg <= cnt_next;
    end
  end

  assign o_code = code_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [15:0] gap_reg;

  // Cycles since the applied code last moved, saturating.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gap_reg <= blfg_pkg::STEP_CNT_RST;
    end else if (code_next != code_reg) begin
      gap_reg <= blfg_pkg::STEP_CNT_RST;
    end else if (gap_reg != 16'hFFFF) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  no_fade_jump_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    !i_fade_active |=> (o_code == $past(i_target)))
    else $error("Code did not follow target with fade off.");

  single_step_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    i_fade_active |=> (o_code == $past(o_code)) ||
      (o_code == $past(o_code) + 8'h01) ||
      (o_code == $past(o_code) - 8'h01))
    else $error("Fade moved the code by more than one step.");

  step_gap_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    ($past(i_fade_active) && (o_code != $past(o_code))) |->
      ($past(gap_reg) >= 16'(P_FAST_STEP_CYC - 1)))
    else $error("Fade step came sooner than the step interval.");

endmodule // blfg_fade_ramp

// File: rtl/blfg_top.sv
// Backlight current control with fade ramps and a three-pin I/O port.
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Operation
// ------------------------------------------------------------------------
// Operation
// - Fade ramps current only while fade_enable is set, else jumps.
// - Full-scale fade takes 1.3 s at rate 0, 0.65 s at rate 1.
// - Fade target select 0 ramps primary string, 1 ramps secondary.
// - Smaller code changes finish in proportionally shorter time.
// - Shared mode drives both strings from the primary code.
// - Shared mode with target 0 ramps both strings together.
// - Current codes at 04H and 05H are 8 bits, 0.1 mA a step.
// - Register 06H bits 2:0 set each pin input (0) or output (1).
// - PWM input select makes pin 0 an input despite its direction.
// - Only pin 0 carries PWM; pins 1 and 2 are plain I/O.
// - Output pins drive the levels held in register 07H bits 2:0.
// - Reading 07H returns the real pin levels in any direction.
// - Register 2BH enables external dimming per string.
// - Dimmed strings conduct while pin 0 is high, off while low.
module blfg_top #(
  parameter int unsigned P_SLOW_STEP_CYC = blfg_pkg::FADE_SLOW_STEP_CYC,
  parameter int unsigned P_FAST_STEP_CYC = blfg_pkg::FADE_FAST_STEP_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire blfg_pkg::blfg_reg_req_s i_reg,
  output logic [7:0] o_reg_rdata,
  input wire logic [2:0] i_gpio_pin,
  output logic [2:0] o_gpio_out,
  output logic [2:0] o_gpio_oe,
  output logic [7:0] o_primary_code,
  output logic [7:0] o_secondary_code,
  output logic o_primary_on,
  output logic o_secondary_on
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  wire wr_ctrl = i_reg.wr &&
    addr_hit(i_reg.addr, blfg_pkg::WHITE_LED_CONTROL_OFF);
  wire wr_pri = i_reg.wr &&
    addr_hit(i_reg.addr, blfg_pkg::PRIMARY_CURRENT_CODE_OFF);
  wire wr_sec = i_reg.wr &&
    addr_hit(i_reg.addr, blfg_pkg::SECONDARY_CURRENT_CODE_OFF);
  wire wr_dir = i_reg.wr &&
    addr_hit(i_reg.addr, blfg_pkg::PIN_DIRECTION_CONTROL_OFF);
  wire wr_data = i_reg.wr &&
    addr_hit(i_reg.addr, blfg_pkg::PIN_LEVEL_DATA_OFF);
  wire wr_dim = i_reg.wr &&
    addr_hit(i_reg.addr, blfg_pkg::EXT_DIM_CONTROL_OFF);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  blfg_pkg::blfg_white_led_ctrl_s ctrl_reg;
  blfg_pkg::blfg_ext_dim_s dim_reg;
  logic [7:0] pri_code_reg;
  logic [7:0] sec_code_reg;
  logic [2:0] dir_reg;
  logic pwm_sel_reg;
  logic [2:0] data_reg;

  // Software writes; unmapped addresses are ignored and reserved bits dropped.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= '0;
      dim_reg <= '0;
      pri_code_reg <= blfg_pkg::CODE_RST;
      sec_code_reg <= blfg_pkg::CODE_RST;
      dir_reg <= blfg_pkg::PIN_BITS_RST;
      pwm_sel_reg <= 1'b0;
      data_reg <= blfg_pkg::PIN_BITS_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= i_reg.wdata[blfg_pkg::CTRL_W-1:0];
      end
      if (wr_pri) begin
        pri_code_reg <= i_reg.wdata;
      end
      if (wr_sec) begin
        sec_code_reg <= i_reg.wdata;
      end
      if (wr_dir) begin
        dir_reg <= i_reg.wdata[blfg_pkg::PIN_CNT-1:0];
        pwm_sel_reg <= i_reg.wdata[blfg_pkg::PWM_SEL_BIT];
      end
      if (wr_data) begin
        data_reg <= i_reg.wdata[blfg_pkg::PIN_CNT-1:0];
      end
      if (wr_dim) begin
        dim_reg <= i_reg.wdata[blfg_pkg::DIM_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin port
  // ----------------------------------------------------------------------
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;

  // Pins are asynchronous to this clock, so two flops precede any use.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta_reg <= blfg_pkg::PIN_BITS_RST;
      pin_sync_reg <= blfg_pkg::PIN_BITS_RST;
    end else begin
      pin_meta_reg <= i_gpio_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Per-pin drivers; only pin 0 can be taken over as the dimming input.
  genvar gp;
  generate
    for (gp = 0; gp < blfg_pkg::PIN_CNT; gp++) begin : g_pin
      if (gp == 0) begin : g_pwm_pin
        assign o_gpio_oe[gp] = dir_reg[gp] && !pwm_sel_reg;
      end else begin : g_plain_pin
        assign o_gpio_oe[gp] = dir_reg[gp];
      end
      assign o_gpio_out[gp] = data_reg[gp];
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [7:0] rdata_mux;
  logic [7:0] rdata_reg;

  // The data register reads back the pins, not the stored output levels.
  always_comb begin
    rdata_mux = 8'h00;
    if (addr_hit(i_reg.addr, blfg_pkg::WHITE_LED_CONTROL_OFF)) begin
      rdata_mux = {2'h0, ctrl_reg};
    end else if (addr_hit(i_reg.addr, blfg_pkg::PRIMARY_CURRENT_CODE_OFF))
    begin
      rdata_mux = pri_code_reg;
    end else if (addr_hit(i_reg.addr, blfg_pkg::SECONDARY_CURRENT_CODE_OFF))
    begin
      rdata_mux = sec_code_reg;
    end else if (addr_hit(i_reg.addr, blfg_pkg::PIN_DIRECTION_CONTROL_OFF))
    begin
      rdata_mux = {3'h0, pwm_sel_reg, 1'b0, dir_reg};
    end else if (addr_hit(i_reg.addr, blfg_pkg::PIN_LEVEL_DATA_OFF)) begin
      rdata_mux = {5'h00, pin_sync_reg};
    end else if (addr_hit(i_reg.addr, blfg_pkg::EXT_DIM_CONTROL_OFF)) begin
      rdata_mux = {6'h00, dim_reg};
    end
  end

  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (i_reg.rd) begin
      rdata_reg <= rdata_mux;
    end
  end

  assign o_reg_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // Fade ramps
  // ----------------------------------------------------------------------
  // Index 0 is the primary string, index 1 the secondary string.
  logic [7:0] ramp_target [2];
  logic [7:0] ramp_code [2];
  logic [1:0] fade_act;

  // In shared mode the secondary string follows the primary code, and a
  // target select of 0 then ramps both strings in lockstep.
  assign ramp_target[0] = pri_code_reg;
  assign ramp_target[1] = ctrl_reg.shared_dac_mode ? pri_code_reg
                                                   : sec_code_reg;
  assign fade_act[0] = ctrl_reg.fade_enable &&
                       !ctrl_reg.fade_target_select;
  assign fade_act[1] = ctrl_reg.fade_enable &&
                       (ctrl_reg.fade_target_select ||
                        ctrl_reg.shared_dac_mode);

  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_ramp
      blfg_fade_ramp #(
        .P_SLOW_STEP_CYC(P_SLOW_STEP_CYC),
        .P_FAST_STEP_CYC(P_FAST_STEP_CYC)
      ) u_ramp (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_target(ramp_target[gs]),
        .i_fade_active(fade_act[gs]),
        .i_fade_fast(ctrl_reg.fade_rate_select),
        .o_code(ramp_code[gs])
      );
    end
  endgenerate

  assign o_primary_code = ramp_code[0];
  assign o_secondary_code = ramp_code[1];

  // ----------------------------------------------------------------------
  // String enables and external dimming
  // ----------------------------------------------------------------------
  // Dimming acts only once pin 0 is configured as the dimming input; a
  // dimming enable made before the pin 0 select lets two stale pin samples reach a string.
  wire pwm_level = pwm_sel_reg && pin_sync_reg[0];
  wire pri_dim = dim_reg.primary_ext_dim_enable && pwm_sel_reg;
  wire sec_dim = dim_reg.secondary_ext_dim_enable && pwm_sel_reg;
  wire pri_on_next = ctrl_reg.primary_string_enable &&
                     (!pri_dim || pwm_level);
  wire sec_on_next = ctrl_reg.secondary_string_enable &&
                     (!sec_dim || pwm_level);
  logic pri_on_reg;
  logic sec_on_reg;

  // Sink enables are registered to keep the outputs free of decode spikes.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pri_on_reg <= 1'b0;
      sec_on_reg <= 1'b0;
    end else begin
      pri_on_reg <= pri_on_next;
      sec_on_reg <= sec_on_next;
    end
  end

  assign o_primary_on = pri_on_reg;
  assign o_secondary_on = sec_on_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence seq_wr_pri;
    i_reg.wr &&
      addr_hit(i_reg.addr, blfg_pkg::PRIMARY_CURRENT_CODE_OFF);
  endsequence

  sequence seq_rd_pri;
    i_reg.rd && !i_reg.wr &&
      addr_hit(i_reg.addr, blfg_pkg::PRIMARY_CURRENT_CODE_OFF);
  endsequence

  code_readback_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    seq_wr_pri ##1 seq_rd_pri |=>
      (o_reg_rdata == $past(i_reg.wdata, 2)))
    else $error("Primary code did not read back as written.");

  shared_follow_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (ctrl_reg.shared_dac_mode && !ctrl_reg.fade_enable) [*2] |->
      (o_secondary_code == o_primary_code))
    else $error("Shared mode strings differ with fade off.");

  both_ramp_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (ctrl_reg.shared_dac_mode && ctrl_reg.fade_enable &&
     !ctrl_reg.fade_target_select) |-> (fade_act == 2'b11))
    else $error("Shared fade does not ramp both strings.");

  pwm_pin_in_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    pwm_sel_reg |-> !o_gpio_oe[0])
    else $error("Pin 0 driven while selected as dimming input.");

  plain_pins_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_dir |=> (o_gpio_oe[2:1] == $past(i_reg.wdata[2:1])))
    else $error("Pins 1 and 2 do not follow their direction bits.");

  pin_drive_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    wr_data |=> (o_gpio_out == $past(i_reg.wdata[2:0])))
    else $error("Output pins do not show the written levels.");

  pin_readback_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_reg.rd && addr_hit(i_reg.addr, blfg_pkg::PIN_LEVEL_DATA_OFF)) |=>
      (o_reg_rdata == {5'h00, $past(i_gpio_pin, 3)}))
    else $error("Data read does not return the pin levels.");

  ext_dim_off_a: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (pri_dim && !pin_sync_reg[0]) |=> !o_primary_on)
    else $error("Dimmed primary string on while pin 0 low.");

endmodule // blfg_top

// File: tb/blfg_pin_model.sv
// Pin-side partner: resolves the three port pins and sources the dim input.
`timescale 1ns/1ps

module blfg_pin_model (
  input wire logic i_sys_clk,
  input wire logic [2:0] i_gpio_out,
  input wire logic [2:0] i_gpio_oe,
  input wire logic [2:0] i_ext_val,
  input wire logic [2:0] i_ext_en,
  output logic [2:0] o_pin
);
  // ----------------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------------
  logic [2:0] float_reg;

  // An undriven pin has no pull, so it wanders rather than hold a level.
  always @(posedge i_sys_clk) begin
    float_reg <= (float_reg === 3'h5) ? 3'h2 : 3'h5;
  end

  // The device drives where enabled; the far side or the float does the rest.
  assign o_pin = (i_gpio_oe & i_gpio_out)
               | (~i_gpio_oe & i_ext_en & i_ext_val)
               | (~i_gpio_oe & ~i_ext_en & float_reg);
endmodule // blfg_pin_model

// File: tb/backlight_fade_and_gpio_tb_top.sv
// Self-checking bench for the backlight fade and pin port block.
`timescale 1ns/1ps

module backlight_fade_and_gpio_tb_top;
  // ----------------------------------------------------------------------
  // Signals and the device
  // ----------------------------------------------------------------------
  localparam int SLOW = 8;
  localparam int FAST = 4;
  logic i_sys_clk;
  logic i_sys_rst;
  blfg_pkg::blfg_reg_req_s req;
  logic [7:0] o_reg_rdata, o_primary_code, o_secondary_code, r;
  logic [2:0] o_gpio_out, o_gpio_oe, pin, ext_val, ext_en;
  logic o_primary_on, o_secondary_on;
  int n_errors = 0;
  int n_compared = 0;
  int mreg [int];
  logic [7:0] addrs [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h2B, 8'h08,
                            8'hFF, 8'h07};

  blfg_top #(.P_SLOW_STEP_CYC(SLOW), .P_FAST_STEP_CYC(FAST)) u_dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg(req),
    .o_reg_rdata(o_reg_rdata), .i_gpio_pin(pin), .o_gpio_out(o_gpio_out),
    .o_gpio_oe(o_gpio_oe), .o_primary_code(o_primary_code),
    .o_secondary_code(o_secondary_code), .o_primary_on(o_primary_on),
    .o_secondary_on(o_secondary_on));

  blfg_pin_model u_pins (.i_sys_clk(i_sys_clk), .i_gpio_out(o_gpio_out),
    .i_gpio_oe(o_gpio_oe), .i_ext_val(ext_val), .i_ext_en(ext_en),
    .o_pin(pin));

  // The clock runs at 10 MHz.
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  // Every comparison goes through here so that none is left uncounted.
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Writable bits of each register; unmapped places keep nothing.
  function automatic int mask_of(input int a);
    case (a)
      3: return 8'h3F;
      4, 5: return 8'hFF;
      6: return 8'h17;
      7: return 8'h07;
      8'h2B: return 8'h03;
      default: return 0;
    endcase
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  // A strobe lasts one cycle and leaves one idle cycle after it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge i_sys_clk);
    req.wr = 1'b0;
    mreg[a] = d & mask_of(a);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge i_sys_clk);
    req.rd = 1'b0;
    chk("read data", o_reg_rdata, exp);
  endtask

  // Follows a ramp step by step; the first step's delay is not fixed.
  task automatic ramp(input bit sec, input int tgt, input int per,
                      input bit both);
    int cur;
    int n;
    int k;
    k = 0;
    cur = sec ? o_secondary_code : o_primary_code;
    while (cur != tgt && k < 300) begin
      n = 0;
      while ((sec ? o_secondary_code : o_primary_code) == cur
             && n < 3 * per) begin
        @(negedge i_sys_clk);
        n++;
      end
      cur += (tgt > cur) ? 1 : -1;
      chk("ramp code", sec ? o_secondary_code : o_primary_code, 8'(cur));
      if (k > 0) chk("step interval", 8'(n), 8'(per));
      if (both) chk("shared ramp", o_secondary_code, 8'(cur));
      k++;
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(31024));
    i_sys_rst = 1'b1;
    req = '0;
    ext_val = 3'h0;
    ext_en = 3'h7;
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    // Without fading a new code applies at once.
    wr(8'h03, 8'h03);
    r = 8'($urandom);
    wr(8'h04, r);
    cyc(2);
    chk("primary code", o_primary_code, r);
    r = 8'($urandom);
    wr(8'h05, r);
    cyc(2);
    chk("secondary code", o_secondary_code, r);
    wr(8'h03, 8'h07);
    cyc(3);
    chk("shared code", o_secondary_code, 8'(mreg[4]));
    // Slow fade on the primary string, set up in the advised order.
    wr(8'h03, 8'h0B);
    wr(8'h04, 8'h06);
    ramp(1'b0, 6, SLOW, 1'b0);
    wr(8'h05, 8'h20);
    cyc(3);
    chk("unramped secondary", o_secondary_code, 8'h20);
    // Fast fade on the secondary string; the primary jumps.
    wr(8'h03, 8'h3B);
    wr(8'h05, 8'h24);
    ramp(1'b1, 8'h24, FAST, 1'b0);
    wr(8'h04, 8'h09);
    cyc(3);
    chk("unramped primary", o_primary_code, 8'h09);
    wr(8'h03, 8'h07);
    cyc(3);
    chk("shared code", o_secondary_code, 8'h09);
    wr(8'h03, 8'h2F);
    wr(8'h04, 8'h0C);
    ramp(1'b0, 12, FAST, 1'b1);
    // Pin port: all outputs first, then pin 0 driven from outside.
    ext_en = 3'h0;
    r = 8'($urandom);
    wr(8'h06, 8'h07);
    wr(8'h07, r);
    chk("pin enables", {5'h0, o_gpio_oe}, 8'h07);
    chk("pin outputs", {5'h0, o_gpio_out}, r & 8'h07);
    cyc(3);
    rd_chk(8'h07, r & 8'h07);
    wr(8'h06, 8'h06);
    ext_val = {2'h0, ~r[0]};
    ext_en = 3'h1;
    cyc(4);
    rd_chk(8'h07, {5'h0, r[2:1], ~r[0]});
    wr(8'h06, 8'h17);
    chk("pin enables", {5'h0, o_gpio_oe}, 8'h06);
    chk("pin outputs", {6'h0, o_gpio_out[2:1]}, {6'h0, r[2:1]});
    // External dimming of both strings, then of the primary alone.
    wr(8'h2B, 8'h03);
    wr(8'h03, 8'h03);
    ext_val = 3'h1;
    cyc(4);
    chk("sinks on", {6'h0, o_primary_on, o_secondary_on}, 8'h03);
    ext_val = 3'h0;
    cyc(4);
    chk("sinks on", {6'h0, o_primary_on, o_secondary_on}, 8'h00);
    wr(8'h2B, 8'h02);
    cyc(4);
    chk("sinks on", {6'h0, o_primary_on, o_secondary_on}, 8'h01);
    // Random write and read-back, unmapped places included.
    repeat (4) begin
      for (int i = 0; i < 7; i++) begin
        wr(addrs[i], 8'($urandom));
        rd_chk(addrs[i], 8'(mreg[addrs[i]]));
      end
    end
    // A read on the cycle right after a write must see the new value.
    r = 8'($urandom);
    @(negedge i_sys_clk);
    req.addr = 8'h04;
    req.wdata = r;
    req.wr = 1'b1;
    @(negedge i_sys_clk);
    req.wr = 1'b0;
    req.rd = 1'b1;
    @(negedge i_sys_clk);
    req.rd = 1'b0;
    chk("write then read", o_reg_rdata, r);
    give_verdict();
  end

  // A hang ends the run as a failure; the tests need under 5000 cycles.
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    n_errors++;
    give_verdict();
  end
endmodule // backlight_fade_and_gpio_tb_top
